// ---- mtx_mac.sv ----
// device end: gap timer, phy control, per-frame control byte and framing
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - full duplex gap is field plus three
// - half duplex gap is field plus six
// - host should use 15h in full duplex
// - host should use 12h in half duplex
// - host keeps phy and mac duplex equal
// - force-link bit reports link always up
// - transmitter-off bit silences the wire output
// - jabber bit disables jabber correction
// - loopback-off bit ignored if loop or full
// - host writes zero to reserved phy bits
// - mac makes preamble, delimiter, pad, crc
// - host stores every other frame field
// - one control byte leads each frame, consumed
// - mac full-duplex bit selects duplex mode
module mtx_mac
   import mtx_pkg::*;
#(
   parameter int MAX_FRAME = MAX_FRAME_DEF
)(
   input  wire logic  ref_clk,
   input  wire logic  rst,
   input  wire logic  ce,
   mtx_link_if.dev    lk,
   input  wire logic  link_partner,
   output logic [3:0] wire_txd,
   output logic       wire_txen,
   output logic [3:0] loop_txd,
   output logic       loop_txen,
   output logic       link_up,
   output logic       jabber_corr_en,
   output logic       tx_done,
   output logic       tx_crc_err,
   output logic       tx_giant
);

   // the byte counter is 16 bits and padding needs a limit of at least 64
   if (MAX_FRAME < 64 || MAX_FRAME > 65535) begin : g_chk
      $error("mtx_mac: MAX_FRAME out of range");
   end

   localparam logic [15:0] MAX_LEN = 16'(MAX_FRAME);

   typedef struct packed {
      mtx_state_t  st;
      logic [3:0]  cnt;
      logic [7:0]  gcnt;
      logic        nib;
      logic [7:0]  byt;
      logic        last;
      logic [15:0] bcnt;
      logic [31:0] crc;
      logic        pad_on;
      logic        pad64;
      logic        crc_on;
      logic        huge;
      logic [6:0]  gap;
      logic [15:0] phy1;
      logic [15:0] phy2;
      logic [7:0]  mac3;
      logic [15:0] rdata;
      logic        rdy;
      logic [3:0]  txd;
      logic [3:0]  wtxd;
      logic        wtxen;
      logic        lpen;
      logic        link;
      logic        jab;
      logic        done;
      logic        crc_err;
      logic        giant;
   } mtx_mac_t;

   mtx_mac_t q;
   mtx_mac_t n;

   logic       acc;
   logic       txen_now;
   logic [3:0] txd_now;
   logic       loop_ok;
   logic       fin;
   logic [7:0] gap_off;
   logic       ovr;

   // whole engine and register file in one pass
   always_comb begin
      n = q;
      n.done = 1'b0;
      n.rdata = 16'h0000;
      txen_now = 1'b0;
      txd_now = 4'h0;
      fin = 1'b0;
      acc = lk.fr_valid & q.rdy;
      ovr = lk.fr_data[PKT_OVR];

      // register writes from the host
      if (lk.reg_wr) begin
         case (lk.reg_addr)
            IDX_GAP:  n.gap  = lk.reg_wdata[6:0];
            IDX_PHY1: n.phy1 = lk.reg_wdata;
            IDX_PHY2: n.phy2 = lk.reg_wdata;
            IDX_MAC3: n.mac3 = lk.reg_wdata[7:0];
            default:  n.gap  = q.gap;
         endcase
      end

      // register reads answer one cycle later; unmapped reads as zero
      if (lk.reg_rd) begin
         case (lk.reg_addr)
            IDX_GAP:  n.rdata = {9'h000, q.gap};
            IDX_PHY1: n.rdata = q.phy1;
            IDX_PHY2: n.rdata = q.phy2;
            IDX_MAC3: n.rdata = {8'h00, q.mac3};
            IDX_STAT: begin
               n.rdata[ST_BUSY]   = q.st != S_IDLE;
               n.rdata[ST_LINK]   = q.link;
               n.rdata[ST_CRCERR] = q.crc_err;
               n.rdata[ST_GIANT]  = q.giant;
            end
            default:  n.rdata = 16'h0000;
         endcase
      end

      // gap offset follows the duplex mode
      gap_off = q.mac3[MAC3_FDX] ? GAP_OFF_FULL
                                 : GAP_OFF_HALF;

      unique case (q.st)
         S_IDLE: begin
            // control byte: consumed here, never sent
            if (acc) begin
               n.pad_on = ovr ? lk.fr_data[PKT_PAD]
                              : q.mac3[MAC3_PADON];
               n.pad64  = ovr ? 1'b0 : q.mac3[MAC3_PAD64];
               n.crc_on = ovr ? lk.fr_data[PKT_CRC]
                              : q.mac3[MAC3_CRC];
               n.huge   = ovr ? lk.fr_data[PKT_HUGE]
                              : q.mac3[MAC3_HUGE];
               n.cnt = 4'h0;
               n.crc = CRC_INIT;
               n.bcnt = 16'h0000;
               n.crc_err = 1'b0;
               n.giant = 1'b0;
               n.st = S_PRE;
            end
         end
         S_PRE: begin
            // preamble nibbles then the delimiter, made here
            txen_now = 1'b1;
            txd_now = (q.cnt == PRE_LAST) ? SFD_NIB : PRE_NIB;
            if (q.cnt != PRE_LAST) n.cnt = q.cnt + 4'h1;
            else if (acc) n.st = S_DATA;
         end
         S_DATA: begin
            txen_now = 1'b1;
            txd_now = q.nib ? q.byt[7:4] : q.byt[3:0];
            if (!q.nib) begin
               n.nib = 1'b1;
            end else if (q.last) begin
               if (q.pad_on &&
                   q.bcnt < (q.pad64 ? LEN_PAD64 : LEN_PAD60)) begin
                  // zero pad byte goes through the crc like data
                  n.byt = 8'h00;
                  n.crc = mtx_crc_byte(q.crc, 8'h00);
                  n.bcnt = q.bcnt + 16'h0001;
                  n.nib = 1'b0;
               end else if (q.crc_on) begin
                  n.crc = ~q.crc;
                  n.cnt = 4'h0;
                  n.st = S_FCS;
               end else begin
                  // last four bytes were the sender's own check value
                  n.crc_err = q.crc != CRC_RESIDUE;
                  fin = 1'b1;
               end
            end
         end
         S_FCS: begin
            txen_now = 1'b1;
            txd_now = q.crc[3:0];
            n.crc = q.crc >> 4;
            n.cnt = q.cnt + 4'h1;
            if (q.cnt == FCS_LAST) fin = 1'b1;
         end
         S_GAP: begin
            if (q.gcnt == GAP_ONE) n.st = S_IDLE;
            else n.gcnt = q.gcnt - GAP_ONE;
         end
         S_DROP: begin
            // oversize frame: swallow the rest without sending it
            if (acc && lk.fr_last) fin = 1'b1;
         end
         default: n.st = S_IDLE;
      endcase

      // take a frame byte into the crc and the length check
      if (acc && (q.st == S_PRE || q.st == S_DATA)) begin
         n.byt = lk.fr_data;
         n.crc = mtx_crc_byte(q.crc, lk.fr_data);
         n.bcnt = q.bcnt + 16'h0001;
         n.last = lk.fr_last;
         n.nib = 1'b0;
         n.st = S_DATA;
         if (!q.huge && n.bcnt > MAX_LEN) begin
            n.giant = 1'b1;
            n.st = S_DROP;
            fin = lk.fr_last;
         end
      end

      // end of frame: one idle cycle takes the next control byte,
      // so the gap counter is loaded one short of the full gap
      if (fin) begin
         n.done = 1'b1;
         n.st = S_GAP;
         n.gcnt = {1'b0, q.gap} + gap_off - GAP_ONE;
      end

      n.rdy = (n.st == S_IDLE) || (n.st == S_DROP) ||
              (n.st == S_PRE && n.cnt == PRE_LAST) ||
              (n.st == S_DATA && n.nib && !n.last);

      // phy side: loopback in half duplex unless turned off, and in any duplex when the loop bit is set
      loop_ok = q.phy1[PHY1_LOOP] ||
                (!q.phy1[PHY1_DPX] && !q.phy2[PHY2_HDLOFF]);
      n.txd = txd_now;
      // wire nibble gated here so the pin comes straight from a flop
      n.wtxd = q.phy2[PHY2_TXOFF] ? 4'h0 : txd_now;
      n.wtxen = txen_now & ~q.phy2[PHY2_TXOFF];
      n.lpen = txen_now & loop_ok;
      n.link = link_partner | q.phy2[PHY2_FORCE_LINK_UP];
      n.jab = ~q.phy2[PHY2_JABOFF];
   end

   // state register; clock enable freezes everything
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         q <= '0;
         q.st <= S_IDLE;
      end else if (ce) begin
         q <= n;
      end
   end

   // link and pin outputs, all from flops
   assign lk.reg_rdata   = q.rdata;
   assign lk.fr_ready    = q.rdy;
   assign wire_txd       = q.wtxd;
   assign wire_txen      = q.wtxen;
   assign loop_txd       = q.txd;
   assign loop_txen      = q.lpen;
   assign link_up        = q.link;
   assign jabber_corr_en = q.jab;
   assign tx_done        = q.done;
   assign tx_crc_err     = q.crc_err;
   assign tx_giant       = q.giant;

endmodule
`default_nettype wire

// ---- mtx_pkg.sv ----
// shared constants, field positions and helpers for the transmit config link
package mtx_pkg;

   // register indices on the link and on the host command port
   localparam logic [2:0] IDX_GAP  = 3'h0;
   localparam logic [2:0] IDX_PHY1 = 3'h1;
   localparam logic [2:0] IDX_PHY2 = 3'h2;
   localparam logic [2:0] IDX_MAC3 = 3'h3;
   localparam logic [2:0] IDX_STAT = 3'h4;
   localparam logic [2:0] IDX_PKT  = 3'h5;

   // field positions
   localparam int PHY1_LOOP   = 14;
   localparam int PHY1_DPX    = 8;
   localparam int PHY2_FORCE_LINK_UP = 14;
   localparam int PHY2_TXOFF  = 13;
   localparam int PHY2_JABOFF = 10;
   localparam int PHY2_HDLOFF = 8;
   localparam logic [15:0] PHY2_MASK = 16'h6500;
   localparam int MAC3_FDX    = 0;
   localparam int MAC3_HUGE   = 2;
   localparam int MAC3_CRC    = 4;
   localparam int MAC3_PADON  = 5;
   localparam int MAC3_PAD64  = 6;
   localparam int PKT_OVR     = 0;
   localparam int PKT_CRC     = 1;
   localparam int PKT_PAD     = 2;
   localparam int PKT_HUGE    = 3;
   localparam int ST_BUSY     = 0;
   localparam int ST_LINK     = 1;
   localparam int ST_CRCERR   = 2;
   localparam int ST_GIANT    = 3;

   // gap encoding and recommended settings, in nibble times
   localparam logic [7:0] GAP_OFF_FULL = 8'h03;
   localparam logic [7:0] GAP_OFF_HALF = 8'h06;
   localparam logic [6:0] GAP_REC_FULL = 7'h15;
   localparam logic [6:0] GAP_REC_HALF = 7'h12;
   localparam logic [7:0] GAP_ONE      = 8'h01;

   // framing
   localparam logic [3:0]  PRE_LAST   = 4'hf;
   localparam logic [3:0]  PRE_NIB    = 4'h5;
   localparam logic [3:0]  SFD_NIB    = 4'hd;
   localparam logic [3:0]  FCS_LAST   = 4'h7;
   localparam logic [15:0] LEN_PAD60  = 16'h003c;
   localparam logic [15:0] LEN_PAD64  = 16'h0040;
   localparam int          MAX_FRAME_DEF = 1518;
   localparam logic [31:0] CRC_INIT    = 32'hffff_ffff;
   localparam logic [31:0] CRC_POLY    = 32'hedb8_8320;
   localparam logic [31:0] CRC_RESIDUE = 32'hdebb_20e3;

   // transmit engine states
   typedef enum logic [5:0] {
      S_IDLE = 6'b00_0001,
      S_PRE  = 6'b00_0010,
      S_DATA = 6'b00_0100,
      S_FCS  = 6'b00_1000,
      S_GAP  = 6'b01_0000,
      S_DROP = 6'b10_0000
   } mtx_state_t;

   // reflected crc-32 update over one byte
   function automatic logic [31:0] mtx_crc_byte(input logic [31:0] c,
                                                input logic [7:0]  d);
      logic [31:0] r;
      r = c ^ {24'h00_0000, d};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

endpackage

// ---- mtx_link_if.sv ----
// link between the host controller and the transmit mac
`timescale 1ns/1ps
`default_nettype none
interface mtx_link_if;
   logic        reg_wr;
   logic        reg_rd;
   logic [2:0]  reg_addr;
   logic [15:0] reg_wdata;
   logic [15:0] reg_rdata;
   logic        fr_valid;
   logic [7:0]  fr_data;
   logic        fr_last;
   logic        fr_ready;

   modport dev  (input  reg_wr, reg_rd, reg_addr, reg_wdata,
                 fr_valid, fr_data, fr_last,
                 output reg_rdata, fr_ready);
   modport host (output reg_wr, reg_rd, reg_addr, reg_wdata,
                 fr_valid, fr_data, fr_last,
                 input  reg_rdata, fr_ready);
endinterface
`default_nettype wire

// ---- mtx_host.sv ----
// host end: programs the mac and feeds frames with their control byte
`timescale 1ns/1ps
`default_nettype none
module mtx_host
   import mtx_pkg::*;
(
   input  wire logic    ref_clk,
   input  wire logic    rst,
   input  wire logic    ce,
   mtx_link_if.host     lk,
   input  wire logic [2:0]  cmd_addr,
   input  wire logic [15:0] cmd_wdata,
   input  wire logic        cmd_wr,
   input  wire logic        cmd_rd,
   output logic [15:0]      cmd_rdata,
   input  wire logic        s_valid,
   input  wire logic [7:0]  s_data,
   input  wire logic        s_last,
   output logic             s_ready
);

   typedef struct packed {
      logic [6:0]  gap;
      logic [15:0] phy1;
      logic [15:0] phy2;
      logic [7:0]  mac3;
      logic [7:0]  pkt;
      logic        sync;
      logic        wr;
      logic        rd;
      logic        rdp;
      logic [2:0]  addr;
      logic [15:0] wdata;
      logic        fv;
      logic [7:0]  fd;
      logic        fl;
      logic        infr;
      logic        srdy;
      logic [15:0] rdata;
      logic [15:0] dstat;
   } mtx_host_t;

   mtx_host_t q;
   mtx_host_t n;

   // command decode, duplex upkeep, status polling and frame feeding
   always_comb begin
      n = q;
      n.wr = 1'b0;
      n.rd = 1'b0;
      n.rdp = q.rd;
      n.rdata = 16'h0000;
      if (cmd_wr) begin
         n.addr = cmd_addr;
         n.wr = 1'b1;
         case (cmd_addr)
            IDX_GAP: begin
               // zero asks for the standard minimum for the duplex in use
               if (cmd_wdata[6:0] == 7'h00)
                  n.gap = q.mac3[MAC3_FDX] ? GAP_REC_FULL
                                           : GAP_REC_HALF;
               else
                  n.gap = cmd_wdata[6:0];
               n.wdata = {9'h000, n.gap};
            end
            IDX_PHY1: begin
               n.phy1 = cmd_wdata;
               n.phy1[PHY1_DPX] = q.mac3[MAC3_FDX];
               n.wdata = n.phy1;
            end
            IDX_PHY2: begin
               n.phy2 = cmd_wdata & PHY2_MASK;
               n.wdata = n.phy2;
            end
            IDX_MAC3: begin
               n.mac3 = cmd_wdata[7:0];
               n.sync = 1'b1;
               n.wdata = {8'h00, n.mac3};
            end
            IDX_PKT: begin
               n.pkt = cmd_wdata[7:0];
               n.wr = 1'b0;
            end
            default: n.wr = 1'b0;
         endcase
      end else if (q.sync) begin
         // follow a duplex change with the matching phy duplex bit
         n.sync = 1'b0;
         n.wr = 1'b1;
         n.addr = IDX_PHY1;
         n.phy1[PHY1_DPX] = q.mac3[MAC3_FDX];
         n.wdata = n.phy1;
      end else begin
         n.rd = 1'b1;
         n.addr = IDX_STAT;
      end
      if (q.rdp) n.dstat = lk.reg_rdata;
      if (cmd_rd) begin
         case (cmd_addr)
            IDX_GAP:  n.rdata = {9'h000, q.gap};
            IDX_PHY1: n.rdata = q.phy1;
            IDX_PHY2: n.rdata = q.phy2;
            IDX_MAC3: n.rdata = {8'h00, q.mac3};
            IDX_STAT: n.rdata = q.dstat;
            IDX_PKT:  n.rdata = {8'h00, q.pkt};
            default:  n.rdata = 16'h0000;
         endcase
      end
      // one-byte slot; outside an oversize drop the mac takes a byte every other cycle at most
      if (q.fv && lk.fr_ready) n.fv = 1'b0;
      if (!n.fv) begin
         if (!q.infr && s_valid) begin
            n.fv = 1'b1;
            n.fd = q.pkt;
            n.fl = 1'b0;
            n.infr = 1'b1;
         end else if (q.infr && s_valid && q.srdy) begin
            n.fv = 1'b1;
            n.fd = s_data;
            n.fl = s_last;
            n.infr = ~s_last;
         end
      end
      n.srdy = ~n.fv & n.infr;
   end

   // state register
   always_ff @(posedge ref_clk) begin
      if (rst) q <= '0;
      else if (ce) q <= n;
   end

   assign lk.reg_wr    = q.wr;
   assign lk.reg_rd    = q.rd;
   assign lk.reg_addr  = q.addr;
   assign lk.reg_wdata = q.wdata;
   assign lk.fr_valid  = q.fv;
   assign lk.fr_data   = q.fd;
   assign lk.fr_last   = q.fl;
   assign cmd_rdata    = q.rdata;
   assign s_ready      = q.srdy;

endmodule
`default_nettype wire

// ---- mtx_link_asserts.sv ----
// concurrent checks on the host to mac link signals
`timescale 1ns/1ps
`default_nettype none
module mtx_link_asserts
   import mtx_pkg::*;
(
   input wire logic        ref_clk,
   input wire logic        rst,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [2:0]  reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata,
   input wire logic        fr_valid,
   input wire logic [7:0]  fr_data,
   input wire logic        fr_last,
   input wire logic        fr_ready
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   logic take;
   logic in_fr_q;
   logic in_fr_d;
   // a control byte opens a frame, the byte marked last closes it
   assign take = fr_valid & fr_ready;
   assign in_fr_d = take ? (!in_fr_q | !fr_last) : in_fr_q;
   always_ff @(posedge ref_clk) begin
      if (rst)
         in_fr_q <= 1'b0;
      else
         in_fr_q <= in_fr_d;
   end
   sequence s_ctrl_take;
      take && !in_fr_q;
   endsequence
   sequence s_mac3_wr;
      reg_wr && reg_addr == IDX_MAC3;
   endsequence
   sequence s_phy1_mirror;
      reg_wr && reg_addr == IDX_PHY1 &&
      reg_wdata[PHY1_DPX] == $past(reg_wdata[MAC3_FDX]);
   endsequence
   a_phy2_rsvd_zero:
      assert property (reg_wr && reg_addr == IDX_PHY2 |->
         (reg_wdata & ~PHY2_MASK) == 16'h0000)
      else $error("reserved phy bits written");
   a_duplex_mirror:
      assert property (s_mac3_wr |=> s_phy1_mirror)
      else $error("phy duplex not mirrored");
   a_gap_not_zero:
      assert property (reg_wr && reg_addr == IDX_GAP |->
         reg_wdata[6:0] != 7'h00)
      else $error("gap field written as zero");
   a_byte_hold:
      assert property (fr_valid && !fr_ready |=>
         fr_valid && $stable(fr_data) && $stable(fr_last))
      else $error("frame byte dropped before taken");
   a_ctrl_not_last:
      assert property (s_ctrl_take |-> !fr_last)
      else $error("frame without data byte");
   a_preamble_hold:
      assert property (s_ctrl_take |-> ##2 !fr_ready [*8])
      else $error("ready during preamble");
   a_data_spacing:
      assert property (take && in_fr_q && !fr_last |->
         ##1 !take ##1 take)
      else $error("data bytes not two cycles apart");
   a_rd_idle_zero:
      assert property (!reg_rd |=> reg_rdata == 16'h0000)
      else $error("read data outside answer cycle");
   a_stat_width:
      assert property (reg_rd && reg_addr == IDX_STAT |=>
         reg_rdata[15:4] == 12'h000)
      else $error("status upper bits set");
endmodule
`default_nettype wire

// ---- tb.sv ----
// self-checking bench: host and mac joined over the link interface
`timescale 1ns/1ps
`default_nettype none
module tb;
   import mtx_pkg::*;
   logic        ref_clk = 1'b0;
   logic        rst = 1'b1;
   logic        ce = 1'b1;
   logic        link_partner = 1'b0;
   logic [2:0]  cmd_addr = 3'h0;
   logic [15:0] cmd_wdata = 16'h0000;
   logic        cmd_wr = 1'b0;
   logic        cmd_rd = 1'b0;
   logic [15:0] cmd_rdata;
   logic        s_valid = 1'b0;
   logic [7:0]  s_data = 8'h00;
   logic        s_last = 1'b0;
   logic        s_ready;
   logic [3:0]  wire_txd;
   logic        wire_txen;
   logic [3:0]  loop_txd;
   logic        loop_txen;
   logic        link_up;
   logic        jabber_corr_en;
   logic        tx_done;
   logic        tx_crc_err;
   logic        tx_giant;
   int          n_fail = 0;
   int          total_checks = 0;
   int          n_done = 0;
   int          idle = 0;
   int          exp_gap = 0;
   bit          skip_gap = 1'b1;
   bit          was_on = 1'b0;
   bit          saw_loop = 1'b0;
   logic [8:0]  sq[$];
   logic [3:0]  cap[$];
   logic [3:0]  exp_nib[$];
   bit          exp_err[$];
   int          exp_tot[$];
   bit          exp_loop[$];

   always #12.5 ref_clk = ~ref_clk;

   mtx_link_if lk ();
   mtx_host u_mtx_host (.ref_clk(ref_clk), .rst(rst), .ce(ce), .lk(lk),
      .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr),
      .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata), .s_valid(s_valid),
      .s_data(s_data), .s_last(s_last), .s_ready(s_ready));
   mtx_mac u_mtx_mac (.ref_clk(ref_clk), .rst(rst), .ce(ce), .lk(lk),
      .link_partner(link_partner), .wire_txd(wire_txd),
      .wire_txen(wire_txen), .loop_txd(loop_txd), .loop_txen(loop_txen),
      .link_up(link_up), .jabber_corr_en(jabber_corr_en),
      .tx_done(tx_done), .tx_crc_err(tx_crc_err), .tx_giant(tx_giant));
   mtx_link_asserts u_chk (.ref_clk(ref_clk), .rst(rst),
      .reg_wr(lk.reg_wr), .reg_rd(lk.reg_rd), .reg_addr(lk.reg_addr),
      .reg_wdata(lk.reg_wdata), .reg_rdata(lk.reg_rdata),
      .fr_valid(lk.fr_valid), .fr_data(lk.fr_data),
      .fr_last(lk.fr_last), .fr_ready(lk.fr_ready));

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] want,
                        input string what);
      total_checks++;
      if (seen !== want) begin
         n_fail++;
         $display("BAD %0t %s seen %0h want %0h", $time, what, seen, want);
      end
   endtask

   // user stream: the queue is filled a whole batch ahead, so no underrun
   always @(posedge ref_clk) begin
      if (s_valid && s_ready)
         void'(sq.pop_front());
      s_valid <= (sq.size() > 0);
      s_data <= sq[0][7:0];
      s_last <= sq[0][8];
   end

   task automatic end_frame();
      int l;
      logic [3:0] w;
      l = exp_tot.pop_front();
      check(cap.size(), l, "nibbles");
      // every expected nibble is consumed so a short frame cannot skew
      for (int i = 0; i < l; i++) begin
         w = exp_nib.pop_front();
         if (i < cap.size())
            check(cap[i], w, "nibble");
      end
      check(saw_loop, exp_loop.pop_front(), "loopback");
      cap.delete();
      saw_loop = 1'b0;
   endtask

   // wire watcher: idle nibbles before each frame, content at its end
   always @(posedge ref_clk) begin
      if (!rst && (wire_txen || loop_txen)) begin
         if (!was_on && !skip_gap)
            check(idle, exp_gap, "gap");
         skip_gap = 1'b0;
         idle = 0;
         cap.push_back(wire_txen ? wire_txd : loop_txd);
         saw_loop |= loop_txen;
      end else if (!rst) begin
         idle++;
         if (was_on)
            end_frame();
      end
      was_on = !rst && (wire_txen || loop_txen);
      if (!rst && tx_done === 1'b1) begin
         n_done++;
         check(tx_crc_err, exp_err.pop_front(), "crc flag");
         check(tx_giant, 1'b0, "giant");
      end
   end

   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      cmd_addr <= a;
      cmd_wdata <= d;
      cmd_wr <= 1'b1;
      @(posedge ref_clk);
      cmd_wr <= 1'b0;
      repeat (2) @(posedge ref_clk);
   endtask

   task automatic rd(input logic [2:0] a, input logic [15:0] e);
      cmd_addr <= a;
      cmd_rd <= 1'b1;
      @(posedge ref_clk);
      cmd_rd <= 1'b0;
      @(posedge ref_clk);
      check(cmd_rdata, e, "read");
   endtask

   // reference crc-32, reflected, one byte at a time
   function automatic logic [31:0] ref_crc(input logic [31:0] c,
                                           input logic [7:0]  d);
      logic [31:0] r;
      r = c ^ {24'h00_0000, d};
      for (int i = 0; i < 8; i++)
         r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
      return r;
   endfunction

   // one user frame; mac3 has crc on and padding off
   task automatic frame(input logic [7:0] c, input bit on, input bit lp);
      int n;
      int m;
      int t;
      logic [7:0] b;
      logic [31:0] r;
      n = 1 + $urandom_range(7);
      m = (c[0] && c[2]) ? 60 : n;
      t = 16 + 2 * m + ((c[0] && !c[1]) ? 0 : 8);
      r = CRC_INIT;
      for (int i = 0; i < 16; i++)
         exp_nib.push_back(i < 15 ? PRE_NIB : SFD_NIB);
      for (int i = 0; i < m; i++) begin
         b = (i < n) ? 8'($urandom) : 8'h00;
         if (i < n)
            sq.push_back({i == n - 1, b});
         r = ref_crc(r, b);
         exp_nib.push_back(b[3:0]);
         exp_nib.push_back(b[7:4]);
      end
      // appended check value goes out low nibble first
      for (int i = 16 + 2 * m; i < t; i++)
         exp_nib.push_back(4'(~r >> (4 * (i - 16 - 2 * m))));
      // without an appended crc the last four bytes are checked instead
      exp_err.push_back(t == 16 + 2 * m && r != CRC_RESIDUE);
      if (on) begin
         exp_tot.push_back(t);
         exp_loop.push_back(lp);
      end else
         repeat (t) void'(exp_nib.pop_back());
   endtask

   // program duplex, gap, phy control and control byte, then send two
   task automatic row(input bit d, input logic [15:0] p, input logic [7:0] c);
      logic [6:0] g;
      int k;
      int tgt;
      g = (c == 8'h00) ? 7'h00 : 7'($urandom_range(127, 1));
      link_partner <= 1'($urandom);
      wr(IDX_MAC3, 16'h0010 | 16'(d));
      wr(IDX_GAP, {9'h000, g} | 16'h0080);
      wr(IDX_PHY2, p | (16'($urandom) & ~PHY2_MASK));
      wr(IDX_PKT, {8'h00, c});
      rd(IDX_PHY2, p);
      rd(IDX_GAP, {9'h000, (g != 7'h00) ? g
                           : (d ? GAP_REC_FULL : GAP_REC_HALF)});
      check(link_up, link_partner | p[PHY2_FORCE_LINK_UP], "link");
      check(jabber_corr_en, !p[PHY2_JABOFF], "jabber");
      exp_gap = (g == 7'h00) ? 24 : g + (d ? 3 : 6);
      tgt = n_done + 2;
      @(negedge ref_clk);
      skip_gap = 1'b1;
      repeat (2) frame(c, !p[PHY2_TXOFF], !d && !p[PHY2_HDLOFF]);
      for (k = 0; k < 4000 && n_done < tgt; k++)
         @(posedge ref_clk);
      check(n_done, tgt, "frames done");
      if (n_done < tgt)
         wrap_up();
      @(posedge ref_clk);
   endtask

   initial begin
      void'($urandom(60));
      repeat (4) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      rd(IDX_GAP, 16'h0000);
      rd(IDX_PHY2, 16'h0000);
      rd(3'h7, 16'h0000);
      row(1'b1, 16'h0000, 8'h00);
      row(1'b1, 16'h4400, 8'h01);
      row(1'b0, 16'h0000, 8'h03);
      row(1'b0, 16'h0100, 8'h07);
      row(1'b0, 16'h0000, 8'hf5);
      row(1'b1, 16'h2000, 8'h00);
      wrap_up();
   end
endmodule
`default_nettype wire
